/* File: design/cmp_window_map.vh */
`ifndef CMP_WINDOW_MAP_VH
`define CMP_WINDOW_MAP_VH
// register indexes, byte address is four times the index
`define IDX_MAIN_CONTROL       8'h00
`define IDX_START_CONTROL      8'h01
`define IDX_EVENT_CONTROL      8'h02
`define IDX_IRQ_ENABLE_CLEAR   8'h04
`define IDX_IRQ_ENABLE_SET     8'h05
`define IDX_IRQ_FLAG           8'h06
`define IDX_STATE_STATUS       8'h07
`define IDX_READY_STATUS       8'h08
`define IDX_PAIR_WINDOW_CTRL   8'h0A
`define IDX_SUPPLY_LEVEL       8'h0D
`define IDX_CMP_CONTROL0       8'h10
`define IDX_CMP_CONTROL1       8'h14
// main control fields
`define MAIN_SWRST_BIT         0
`define MAIN_ENABLE_BIT        1
// comparator control fields
`define CC_ENABLE_BIT          1
`define CC_SINGLE_BIT          2
`define CC_IRQSEL_LSB          3
`define CC_STANDBY_BIT         6
`define CC_NEGSEL_LSB          8
`define CC_POSSEL_LSB          12
`define CC_SWAP_BIT            15
`define CC_FILTER_LENGTH_LSB            24
`define CC_OUTSEL_LSB          28
`define CC_WRITE_MASK          32'h3700F75E
// event control fields
`define EV_CMP0_OUT_BIT        0
`define EV_CMP1_OUT_BIT        1
`define EV_WINDOW_ZERO_SOURCE_OUT_BIT        4
`define EV_CMP0_IN_BIT         8
`define EV_CMP1_IN_BIT         9
// interrupt flag and enable positions
`define IRQ_CMP0_BIT           0
`define IRQ_CMP1_BIT           1
`define IRQ_WINDOW_ZERO_SOURCE_BIT           4
// window control and status fields
`define WIN_ENABLE_BIT         0
`define WIN_IRQSEL_LSB         1
`define WSTATE_LSB             4
// encodings
`define WSTATE_ABOVE           2'h0
`define WSTATE_INSIDE          2'h1
`define WSTATE_BELOW           2'h2
`define CIRQ_TOGGLE            2'h0
`define CIRQ_RISE              2'h1
`define CIRQ_FALL              2'h2
`define CIRQ_DONE              2'h3
`define WIRQ_ABOVE             2'h0
`define WIRQ_INSIDE            2'h1
`define WIRQ_BELOW             2'h2
`define WIRQ_OUTSIDE           2'h3
`define FILTER_LENGTH_NONE              3'h0
`define FILTER_LENGTH_MAJ3              3'h1
`define FILTER_LENGTH_MAJ5              3'h2
`define OUTSEL_OFF             2'h0
`define OUTSEL_RAW             2'h1
`define OUTSEL_SYNC            2'h2
`define LADDER_SELECT          3'h5
// timing
`define CLK_PERIOD_NS          4
`define STARTUP_NS             1000
`define STARTUP_CYCLES         ((`STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: design/comparator_window_filter_ctrl.v */
// Overview of operation
// - window state reported, either limit order
// - two-bit select picks window interrupt condition
// - window event follows inside state while window and its event output are enabled
// - comparator logic unchanged in window mode
// - window single-shot start launches both comparators
// - ladder on when select five and enabled
// - second comparator ladder has 64 levels
// - filter length: none, three, five samples
// - majority of last N samples decides
// - filter adds N-1 cycles latency in single-shot, (N-1)/2 in continuous
// - single-shot ready after Nth sample
// - pin gets raw or synchronized result
// - swap exchanges inputs and inverts output
// - one flag per interrupt source
// - set and clear enable registers
// - request is OR of enabled flags
// - enabled output events mirror status
// - input events start comparisons, both in window
// - edges found from previous sample
// - software start clears ready, event does not
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`include "cmp_window_map.vh"
module comparator_window_filter_ctrl (
   input  wire        mclk,                 // peripheral generic clock
   input  wire        rst,                  // synchronous reset, active high
   input  wire        psel,                 // apb select
   input  wire        penable,              // apb access phase
   input  wire        pwrite,               // apb direction
   input  wire [11:0] paddr,                // apb byte address
   input  wire [31:0] pwdata,               // apb write data
   output reg  [31:0] prdata,               // apb read data
   output wire        pready,               // apb ready
   output wire        pslverr,              // apb error on unmapped address
   input  wire [1:0]  cmp_raw,              // raw analog comparator outputs
   output wire [1:0]  cmp_analog_enable,    // analog comparator power
   output wire [1:0]  cmp_swap,             // input terminal exchange
   output wire [5:0]  negative_input_select, // {cmp1, cmp0} negative mux
   output wire [5:0]  positive_input_select, // {cmp1, cmp0} positive mux
   output wire [1:0]  ladder_enable,        // supply fraction reference on
   output wire [5:0]  supply_level,         // programmable ladder level
   input  wire        cmp_zero_pin_enable,  // pin enable for comparator 0
   input  wire        cmp_one_pin_enable,   // pin enable for comparator 1
   input  wire        cmp_one_alt_pin_enable, // comparator 1 to alternate pin
   output wire        cmp_zero_pin,         // comparator 0 pin
   output wire        cmp_one_pin,          // comparator 1 pin
   output wire        cmp_one_alt_pin,      // comparator 1 alternate pin
   input  wire [1:0]  start_event_in,       // start event pulses
   output wire [2:0]  event_out,            // {window, cmp1, cmp0} event levels
   output wire        irq                   // combined interrupt request
);
   localparam [1:0] PH_IDLE = 2'h0;
   localparam [1:0] PH_WARM = 2'h1;
   localparam [1:0] PH_FILL = 2'h2;
   localparam [1:0] PH_RUN  = 2'h3;
   localparam integer STARTUP_N = `STARTUP_CYCLES;
   localparam [8:0]   STARTUP   = STARTUP_N[8:0];

   // majority of the newest N samples
   function maj;
      input [4:0] h;
      input [2:0] fl;
      begin
         case (fl)
            `FILTER_LENGTH_MAJ3: maj = (h[0] & h[1]) | (h[0] & h[2]) | (h[1] & h[2]);
            `FILTER_LENGTH_MAJ5: maj = (h[0] + h[1] + h[2] + h[3] + h[4]) >= 3'd3;
            default:    maj = h[0];
         endcase
      end
   endfunction

   // number of samples per result
   function [2:0] samples;
      input [2:0] fl;
      begin
         case (fl)
            `FILTER_LENGTH_MAJ3: samples = 3'd3;
            `FILTER_LENGTH_MAJ5: samples = 3'd5;
            default:    samples = 3'd1;
         endcase
      end
   endfunction

   // ladder request: comparator on and either mux at the ladder input
   function ladder_req;
      input        on;
      input [31:0] cc;
      begin
         ladder_req = on & ((cc[`CC_NEGSEL_LSB +: 3] == `LADDER_SELECT) |
                            (cc[`CC_POSSEL_LSB +: 3] == `LADDER_SELECT));
      end
   endfunction

   // pin source selection; any other code keeps the pin low
   function pin_pick;
      input [1:0] sel;
      input       raw;
      input       sync;
      begin
         case (sel)
            `OUTSEL_RAW:  pin_pick = raw;
            `OUTSEL_SYNC: pin_pick = sync;
            default:      pin_pick = 1'b0;
         endcase
      end
   endfunction

   reg         main_en_q;
   reg  [31:0] cc_q [0:1];
   reg  [9:0]  event_control_reg_q;
   reg  [4:0]  irq_en_q;
   reg  [4:0]  irq_flag_q;
   reg  [2:0]  pair_window_control_q;
   reg  [5:0]  level_q;
   reg  [1:0]  phase_q [0:1];
   reg  [8:0]  cnt_q [0:1];
   reg  [2:0]  fill_q [0:1];
   reg  [4:0]  hist_q [0:1];
   reg  [1:0]  state_q;
   reg  [1:0]  ready_q;
   reg  [1:0]  wstate_q;
   reg  [1:0]  sync_pin_q;

   wire [7:0]  idx    = paddr[9:2];
   wire        wr     = psel & penable & pwrite;
   wire        rd_set = psel & ~penable & ~pwrite;
   wire        swrst  = wr & (idx == `IDX_MAIN_CONTROL) & pwdata[`MAIN_SWRST_BIT];
   wire        srst   = rst | swrst;
   wire        wen    = pair_window_control_q[`WIN_ENABLE_BIT];
   wire [1:0]  wsel   = pair_window_control_q[`WIN_IRQSEL_LSB +: 2];
   wire [1:0]  sw_start = (wr && idx == `IDX_START_CONTROL) ? pwdata[1:0] : 2'h0;

   reg  [1:0]  en;
   reg  [1:0]  single;
   reg  [1:0]  go;
   reg  [1:0]  valid;
   reg  [1:0]  newres;
   reg  [1:0]  cmp_irq;
   reg  [4:0]  nhist [0:1];
   reg  [1:0]  req;
   reg  [1:0]  wstate_d;
   reg         mapped;

   // start requests: software or enabled events, shared in window single-shot
   always @* begin : start_comb
      integer i;
      for (i = 0; i < 2; i = i + 1) begin
         en[i]     = main_en_q & cc_q[i][`CC_ENABLE_BIT];
         single[i] = cc_q[i][`CC_SINGLE_BIT];
         req[i]    = sw_start[i] | (event_control_reg_q[`EV_CMP0_IN_BIT + i] & start_event_in[i]);
      end
      if (wen && single[0] && single[1])
         go = {2{|req}};
      else
         go = req;
   end

   // sample path: swap inverts the analog result back, then majority vote
   always @* begin : sample_comb
      integer i;
      for (i = 0; i < 2; i = i + 1) begin
         nhist[i]  = {hist_q[i][3:0], cmp_raw[i] ^ cc_q[i][`CC_SWAP_BIT]};
         newres[i] = maj(nhist[i], cc_q[i][`CC_FILTER_LENGTH_LSB +: 3]);
         valid[i]  = ((phase_q[i] == PH_FILL) &&
                      (fill_q[i] + 3'd1 >= samples(cc_q[i][`CC_FILTER_LENGTH_LSB +: 3]))) ||
                     (phase_q[i] == PH_RUN);
         case (cc_q[i][`CC_IRQSEL_LSB +: 2])
            `CIRQ_TOGGLE: cmp_irq[i] = valid[i] & (newres[i] ^ state_q[i]);
            `CIRQ_RISE:   cmp_irq[i] = valid[i] & newres[i] & ~state_q[i];
            `CIRQ_FALL:   cmp_irq[i] = valid[i] & ~newres[i] & state_q[i];
            default:      cmp_irq[i] = valid[i];
         endcase
      end
   end

   // window state from both comparator states, either limit order
   always @* begin
      if (state_q[0] ^ state_q[1])
         wstate_d = `WSTATE_INSIDE;
      else if (state_q[0])
         wstate_d = `WSTATE_ABOVE;
      else
         wstate_d = `WSTATE_BELOW;
   end

   // per comparator sequencer: startup, filter fill, run
   // a disable drops the sequencer at once, even in mid measurement
   always @(posedge mclk) begin : seq_proc
      integer i;
      for (i = 0; i < 2; i = i + 1) begin
         if (srst || !en[i]) begin
            phase_q[i] <= PH_IDLE;
            cnt_q[i]   <= 9'h000;
            fill_q[i]  <= 3'h0;
            hist_q[i]  <= 5'h00;
         end else begin
            case (phase_q[i])
               PH_IDLE: begin
                  if (!single[i] || go[i]) begin
                     phase_q[i] <= PH_WARM;
                     cnt_q[i]   <= STARTUP;
                  end
               end
               PH_WARM: begin
                  cnt_q[i] <= cnt_q[i] - 9'h001;
                  if (cnt_q[i] <= 9'h001) begin
                     phase_q[i] <= PH_FILL;
                     fill_q[i]  <= 3'h0;
                  end
               end
               PH_FILL: begin
                  hist_q[i] <= nhist[i];
                  fill_q[i] <= fill_q[i] + 3'h1;
                  if (valid[i])
                     phase_q[i] <= single[i] ? PH_IDLE : PH_RUN;
               end
               PH_RUN: begin
                  hist_q[i] <= nhist[i];
               end
               default: phase_q[i] <= PH_IDLE;
            endcase
         end
      end
   end

   // results, ready bits, window state and pin synchroniser
   // state is kept over a disable so the next edge compare has a base
   always @(posedge mclk) begin : res_proc
      integer i;
      if (srst) begin
         state_q    <= 2'h0;
         ready_q    <= 2'h0;
         wstate_q   <= `WSTATE_BELOW;
         sync_pin_q <= 2'h0;
      end else begin
         for (i = 0; i < 2; i = i + 1) begin
            if (valid[i] && en[i]) begin
               state_q[i] <= newres[i];
               ready_q[i] <= 1'b1;
            end else if (sw_start[i] || (wen && single[i] && |sw_start) || !en[i]) begin
               ready_q[i] <= 1'b0;
            end
         end
         wstate_q   <= wstate_d;
         sync_pin_q <= state_q;
      end
   end

   // register writes and interrupt flags, set wins over clear
   always @(posedge mclk) begin
      if (srst) begin
         main_en_q  <= 1'b0;
         cc_q[0]    <= 32'h00000000;
         cc_q[1]    <= 32'h00000000;
         event_control_reg_q   <= 10'h000;
         irq_en_q   <= 5'h00;
         irq_flag_q <= 5'h00;
         pair_window_control_q  <= 3'h0;
         level_q    <= 6'h00;
      end else begin
         if (wr) begin
            case (idx)
               `IDX_MAIN_CONTROL:     main_en_q <= pwdata[`MAIN_ENABLE_BIT];
               `IDX_EVENT_CONTROL:    event_control_reg_q  <= pwdata[9:0];
               `IDX_IRQ_ENABLE_SET:   irq_en_q  <= irq_en_q | pwdata[4:0];
               `IDX_IRQ_ENABLE_CLEAR: irq_en_q  <= irq_en_q & ~pwdata[4:0];
               `IDX_PAIR_WINDOW_CTRL: pair_window_control_q <= pwdata[2:0];
               `IDX_SUPPLY_LEVEL:     level_q   <= pwdata[5:0];
               `IDX_CMP_CONTROL0:     cc_q[0]   <= pwdata & `CC_WRITE_MASK;
               `IDX_CMP_CONTROL1:     cc_q[1]   <= pwdata & `CC_WRITE_MASK;
               default: ;
            endcase
         end
         irq_flag_q <= (irq_flag_q & ~((wr && idx == `IDX_IRQ_FLAG) ? pwdata[4:0] : 5'h00)) |
                       {wen && (wstate_d != wstate_q) &&
                        ((wsel == `WIRQ_ABOVE   && wstate_d == `WSTATE_ABOVE) ||
                         (wsel == `WIRQ_INSIDE  && wstate_d == `WSTATE_INSIDE) ||
                         (wsel == `WIRQ_BELOW   && wstate_d == `WSTATE_BELOW) ||
                         (wsel == `WIRQ_OUTSIDE && wstate_q == `WSTATE_INSIDE)),
                        2'h0, cmp_irq & en};
      end
   end

   // address decode for the bus answer
   always @* begin
      case (idx)
         `IDX_MAIN_CONTROL, `IDX_START_CONTROL, `IDX_EVENT_CONTROL,
         `IDX_IRQ_ENABLE_CLEAR, `IDX_IRQ_ENABLE_SET, `IDX_IRQ_FLAG,
         `IDX_STATE_STATUS, `IDX_READY_STATUS, `IDX_PAIR_WINDOW_CTRL,
         `IDX_SUPPLY_LEVEL, `IDX_CMP_CONTROL0, `IDX_CMP_CONTROL1: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // read data is captured in the setup cycle
   always @(posedge mclk) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (rd_set) begin
         case (idx)
            `IDX_MAIN_CONTROL:     prdata <= {30'h0, main_en_q, 1'b0};
            `IDX_EVENT_CONTROL:    prdata <= {22'h0, event_control_reg_q};
            `IDX_IRQ_ENABLE_CLEAR: prdata <= {27'h0, irq_en_q};
            `IDX_IRQ_ENABLE_SET:   prdata <= {27'h0, irq_en_q};
            `IDX_IRQ_FLAG:         prdata <= {27'h0, irq_flag_q};
            `IDX_STATE_STATUS:     prdata <= {26'h0, wstate_q, 2'h0, state_q};
            `IDX_READY_STATUS:     prdata <= {30'h0, ready_q};
            `IDX_PAIR_WINDOW_CTRL: prdata <= {29'h0, pair_window_control_q};
            `IDX_SUPPLY_LEVEL:     prdata <= {26'h0, level_q};
            `IDX_CMP_CONTROL0:     prdata <= cc_q[0];
            `IDX_CMP_CONTROL1:     prdata <= cc_q[1];
            default:               prdata <= 32'h00000000;
         endcase
      end
   end

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // analog controls
   assign cmp_analog_enable     = {phase_q[1] != PH_IDLE, phase_q[0] != PH_IDLE};
   assign cmp_swap              = {cc_q[1][`CC_SWAP_BIT], cc_q[0][`CC_SWAP_BIT]};
   assign negative_input_select = {cc_q[1][`CC_NEGSEL_LSB +: 3], cc_q[0][`CC_NEGSEL_LSB +: 3]};
   assign positive_input_select = {cc_q[1][`CC_POSSEL_LSB +: 3], cc_q[0][`CC_POSSEL_LSB +: 3]};
   assign ladder_enable[0] = ladder_req(en[0], cc_q[0]);
   assign ladder_enable[1] = ladder_req(en[1], cc_q[1]);
   assign supply_level     = level_q;

   // pin routing: raw path is deliberately unsynchronised
   wire [1:0] pin_src;
   assign pin_src[0] = pin_pick(cc_q[0][`CC_OUTSEL_LSB +: 2], cmp_raw[0] ^ cmp_swap[0],
                                sync_pin_q[0]);
   assign pin_src[1] = pin_pick(cc_q[1][`CC_OUTSEL_LSB +: 2], cmp_raw[1] ^ cmp_swap[1],
                                sync_pin_q[1]);
   assign cmp_zero_pin    = cmp_zero_pin_enable & pin_src[0];
   assign cmp_one_pin     = cmp_one_pin_enable & ~cmp_one_alt_pin_enable & pin_src[1];
   assign cmp_one_alt_pin = cmp_one_pin_enable & cmp_one_alt_pin_enable & pin_src[1];

   // output events and combined request
   assign event_out = {event_control_reg_q[`EV_WINDOW_ZERO_SOURCE_OUT_BIT] & wen & (wstate_q == `WSTATE_INSIDE),
                       event_control_reg_q[`EV_CMP1_OUT_BIT] & state_q[1],
                       event_control_reg_q[`EV_CMP0_OUT_BIT] & state_q[0]};
   assign irq = |(irq_flag_q & irq_en_q);
endmodule

/* File: verif/analog_pair_model.sv */
`timescale 1ns/100ps
module analog_pair_model (
   input  wire logic [1:0] powered, // analog enable from the block
   input  wire logic [1:0] level,   // wanted result per comparator
   input  wire logic       mclk,    // clock
   output logic      [1:0] raw      // comparator outputs
);
   logic wander_q = 1'b0;
   // an unpowered comparator gives no valid result, so its output wanders
   always @(posedge mclk) wander_q <= ~wander_q;
   assign raw = (powered & level) | (~powered & {2{wander_q}});
endmodule

/* File: verif/comparator_window_filter_ctrl_tb.sv */
`timescale 1ns/100ps
`include "cmp_window_map.vh"
module comparator_window_filter_ctrl_tb;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [1:0]  level = 2'h0;
   logic [1:0]  start_event_in = 2'h0;
   logic        cmp_zero_pin_enable = 1'b0;
   logic        cmp_one_pin_enable = 1'b0;
   logic        cmp_one_alt_pin_enable = 1'b0;
   logic        cmp_one_pin, cmp_one_alt_pin;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, cmp_zero_pin;
   logic [1:0]  cmp_raw, cmp_analog_enable, cmp_swap, ladder_enable;
   logic [5:0]  negative_input_select, positive_input_select, supply_level;
   logic [2:0]  event_out;
   integer      n_mismatch = 0;
   integer      tests_run = 0;
   integer      cyc = 0;

   // clock and cycle count
   always #2 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;

   comparator_window_filter_ctrl dut_u (
      .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmp_raw(cmp_raw), .cmp_analog_enable(cmp_analog_enable), .cmp_swap(cmp_swap),
      .negative_input_select(negative_input_select), .positive_input_select(positive_input_select),
      .ladder_enable(ladder_enable), .supply_level(supply_level),
      .cmp_zero_pin_enable(cmp_zero_pin_enable), .cmp_one_pin_enable(cmp_one_pin_enable),
      .cmp_one_alt_pin_enable(cmp_one_alt_pin_enable), .cmp_zero_pin(cmp_zero_pin),
      .cmp_one_pin(cmp_one_pin), .cmp_one_alt_pin(cmp_one_alt_pin),
      .start_event_in(start_event_in), .event_out(event_out), .irq(irq));

   analog_pair_model partner_u (.powered(cmp_analog_enable), .level(level), .mclk(mclk),
      .raw(cmp_raw));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer: setup, then access until pready
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd_v, output logic err);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd_v = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, idx, d, r, e);
   endtask

   task automatic rd(input logic [7:0] idx, output logic [31:0] d);
      logic e;
      apb(1'b0, idx, 32'h0, d, e);
   endtask

   task automatic wait_ready(input logic [1:0] mask);
      logic [31:0] d;
      rd(`IDX_READY_STATUS, d);
      while ((d[1:0] & mask) !== mask) rd(`IDX_READY_STATUS, d);
   endtask

   // enable set and clear views, unmapped place, ladder level
   task automatic regs_test;
      logic [31:0] d;
      logic        e;
      wr(`IDX_IRQ_ENABLE_SET, 32'h00000013);
      wr(`IDX_IRQ_ENABLE_CLEAR, 32'h00000002);
      rd(`IDX_IRQ_ENABLE_SET, d);
      chk("enable set view", 32'h00000011, d);
      rd(`IDX_IRQ_ENABLE_CLEAR, d);
      chk("enable clear view", 32'h00000011, d);
      apb(1'b1, 8'h03, 32'hFFFFFFFF, d, e);
      chk("unmapped error", 32'h00000001, {31'h0, e});
      apb(1'b0, 8'h03, 32'h0, d, e);
      chk("unmapped read", 32'h00000000, d);
      wr(`IDX_SUPPLY_LEVEL, 32'h0000003F);
      @(posedge mclk);
      chk("ladder level", 32'h0000003F, {26'h0, supply_level});
      wr(`IDX_IRQ_ENABLE_CLEAR, 32'h00000013);
   endtask

   // comparator 0 single shot, swapped, three sample filter, raw pin
   task automatic single_test;
      logic [31:0] d;
      integer      t0;
      level <= 2'b00;
      cmp_zero_pin_enable <= 1'b1;
      wr(`IDX_MAIN_CONTROL, 32'h00000002);
      wr(`IDX_CMP_CONTROL0, 32'h1100801E);
      wr(`IDX_IRQ_ENABLE_SET, 32'h00000001);
      repeat (2) begin
         wr(`IDX_START_CONTROL, 32'h00000001);
         t0 = cyc;
         rd(`IDX_READY_STATUS, d);
         chk("ready after start", 32'h0, d & 32'h1);
         wait_ready(2'b01);
         chk("start to ready", 32'h1, {31'h0, (cyc - t0) >= 253 && (cyc - t0) <= 260});
      end
      rd(`IDX_STATE_STATUS, d);
      chk("swapped state", 32'h1, d & 32'h1);
      rd(`IDX_IRQ_FLAG, d);
      chk("cmp0 flag", 32'h1, d & 32'h13);
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(`IDX_IRQ_FLAG, 32'h00000001);
      @(posedge mclk);
      chk("irq after clear", 32'h0, {31'h0, irq});
      #1;
      chk("raw pin", {31'h0, ~cmp_raw[0]}, {31'h0, cmp_zero_pin});
      wr(`IDX_CMP_CONTROL0, 32'h00000000);
   endtask

   // window pair started by one event, with both limit orders
   task automatic window_test;
      logic [31:0] d;
      wr(`IDX_MAIN_CONTROL, 32'h00000001); // soft reset puts the window state at below
      wr(`IDX_MAIN_CONTROL, 32'h00000002);
      level <= 2'b01;
      wr(`IDX_CMP_CONTROL0, 32'h00000006);
      wr(`IDX_CMP_CONTROL1, 32'h10000506);
      wr(`IDX_EVENT_CONTROL, 32'h00000313);
      wr(`IDX_PAIR_WINDOW_CTRL, 32'h00000003);
      wr(`IDX_IRQ_ENABLE_SET, 32'h00000010);
      chk("ladder on", 32'h2, {30'h0, ladder_enable});
      @(posedge mclk) start_event_in <= 2'b10;
      @(posedge mclk) start_event_in <= 2'b00;
      wait_ready(2'b11);
      rd(`IDX_STATE_STATUS, d);
      chk("window inside", 32'h11, d & 32'h33);
      chk("events inside", 32'h5, {29'h0, event_out});
      rd(`IDX_IRQ_FLAG, d);
      chk("window flag", 32'h10, d & 32'h10);
      level <= 2'b10;
      @(posedge mclk) start_event_in <= 2'b01;
      @(posedge mclk) start_event_in <= 2'b00;
      rd(`IDX_READY_STATUS, d);
      chk("ready kept", 32'h3, d & 32'h3);
      repeat (260) @(posedge mclk);
      chk("events other order", 32'h6, {29'h0, event_out});
      rd(`IDX_STATE_STATUS, d);
      chk("window inside again", 32'h12, d & 32'h33);
      level <= 2'b01;
      wr(`IDX_START_CONTROL, 32'h00000002);
      rd(`IDX_READY_STATUS, d);
      chk("ready after shared start", 32'h0, d & 32'h3);
      wait_ready(2'b11);
      rd(`IDX_STATE_STATUS, d);
      chk("both on one start", 32'h11, d & 32'h33);
      @(posedge mclk) {cmp_one_pin_enable, cmp_one_alt_pin_enable} <= 2'b11;
      @(posedge mclk) #1;
      chk("alt pin", {30'h0, cmp_raw[1], 1'b0}, {30'h0, cmp_one_alt_pin, cmp_one_pin});
      wr(`IDX_PAIR_WINDOW_CTRL, 32'h00000000);
      wr(`IDX_CMP_CONTROL0, 32'h00000000);
      wr(`IDX_CMP_CONTROL1, 32'h00000000);
   endtask

   // comparator 0 continuous, no filter, rising edge interrupt, synchronised pin
   task automatic cont_test;
      logic [31:0] d;
      level <= 2'b00;
      wr(`IDX_IRQ_FLAG, 32'h00000013);
      wr(`IDX_IRQ_ENABLE_SET, 32'h00000001);
      wr(`IDX_CMP_CONTROL0, 32'h2000000A);
      wait_ready(2'b01);
      level <= 2'b01;
      repeat (3) @(posedge mclk);
      rd(`IDX_IRQ_FLAG, d);
      chk("rise flag", 32'h1, d & 32'h13);
      chk("rise irq", 32'h1, {31'h0, irq});
      chk("sync pin high", 32'h1, {31'h0, cmp_zero_pin});
      wr(`IDX_IRQ_FLAG, 32'h00000001);
      level <= 2'b00;
      repeat (3) @(posedge mclk);
      rd(`IDX_IRQ_FLAG, d);
      chk("no flag on fall", 32'h0, d & 32'h1);
      chk("sync pin low", 32'h0, {31'h0, cmp_zero_pin});
      wr(`IDX_CMP_CONTROL0, 32'h00000000);
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      regs_test;
      single_test;
      window_test;
      cont_test;
      stop_test;
   end

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      stop_test;
   end
endmodule

/* File: verif/window_ctrl_chk.sv */
`timescale 1ns/100ps
module window_ctrl_chk (
   input wire logic       mclk,                  // clock
   input wire logic       rst,                   // reset
   input wire logic       psel,                  // apb select
   input wire logic       penable,               // apb access
   input wire logic       pwrite,                // apb direction
   input wire logic       pready,                // apb ready
   input wire logic       pslverr,               // apb error
   input wire logic [1:0] cmp_swap,              // swap per comparator
   input wire logic [5:0] negative_input_select, // negative mux
   input wire logic [5:0] positive_input_select, // positive mux
   input wire logic [1:0] ladder_enable,         // ladder on
   input wire logic [5:0] supply_level,          // ladder level
   input wire logic [1:0] cmp_analog_enable,     // analog power
   input wire logic       cmp_zero_pin_enable,   // pin enable
   input wire logic       cmp_zero_pin,          // pin
   input wire logic [2:0] event_out,             // output events
   input wire logic       irq                    // interrupt request
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // a register write completes in this cycle
   wire wr_acc = psel && penable && pwrite;

   ready_always_a: assert property (pready) else $error("pready low");
   err_phase_a: assert property (pslverr |-> psel && penable) else $error("pslverr off phase");
   ladder_zero_a: assert property (ladder_enable[0] |->
      negative_input_select[2:0] == 3'h5 || positive_input_select[2:0] == 3'h5)
      else $error("ladder 0 without select");
   ladder_one_a: assert property (ladder_enable[1] |->
      negative_input_select[5:3] == 3'h5 || positive_input_select[5:3] == 3'h5)
      else $error("ladder 1 without select");
   irq_hold_a: assert property (irq && !wr_acc |=> irq)
      else $error("irq dropped without write");
   swap_write_a: assert property ($changed(cmp_swap) |-> $past(wr_acc))
      else $error("swap changed without write");
   level_write_a: assert property ($changed(supply_level) |-> $past(wr_acc))
      else $error("level changed without write");
   warm_hold_a: assert property ($rose(cmp_analog_enable[0]) |=>
      $stable(event_out[0]) [*8]) else $error("result during warm up");
   pin_gate_a: assert property (cmp_zero_pin |-> cmp_zero_pin_enable)
      else $error("pin driven while disabled");
endmodule
bind comparator_window_filter_ctrl window_ctrl_chk chk_u (
   .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .pslverr(pslverr), .cmp_swap(cmp_swap),
   .negative_input_select(negative_input_select), .positive_input_select(positive_input_select),
   .ladder_enable(ladder_enable), .supply_level(supply_level),
   .cmp_analog_enable(cmp_analog_enable), .cmp_zero_pin_enable(cmp_zero_pin_enable),
   .cmp_zero_pin(cmp_zero_pin), .event_out(event_out), .irq(irq));
